// ===== hw/ser_mode_regs.vh
// constants for the serializer mode configuration and link selection block
// assumes 8-bit register offsets and a 40 MHz system clock
`ifndef SER_MODE_REGS_VH
`define SER_MODE_REGS_VH

// ==============================================================
// register offsets
`define ADDR_INPUT_FMT   8'h4F
`define ADDR_LINK_CTL    8'h5B
`define ADDR_RPTR_CFG    8'hC2

// ==============================================================
// field positions
`define BIT_PIX_WIDTH    6
`define BIT_MAP_SEL      7
`define BIT_CABLE        7
`define BIT_RPTR_EN      5
`define BIT_AUTO_OFF     0
`define FLD_FORCE_LO     1
`define FLD_FORCE_HI     2
`define FLD_STAT_LO      3
`define FLD_STAT_HI      5

// ==============================================================
// forced mode codes and status codes
`define FORCE_SINGLE     2'h0
`define FORCE_DUAL       2'h1
`define FORCE_REPL       2'h2
`define FORCE_SECOND     2'h3
`define STAT_RESOLVE     3'h0
`define STAT_SINGLE      3'h1
`define STAT_DUAL        3'h2
`define STAT_REPL        3'h3
`define STAT_SECOND      3'h4
`define STAT_IDLE        3'h5

// ==============================================================
// reset values and bus address
`define RST_INPUT_FMT    8'h00
`define RST_LINK_CTL     8'h00
`define RST_RPTR_CFG     8'h00
`define I2C_DEV_ADDR     7'h0C

// ==============================================================
// timing: measurement window and pixel frequency limits
`define CLK_MHZ          40
`define WIN_US           100
`define WIN_CYC          (`WIN_US * `CLK_MHZ)
`define TICK_DIV         64
`define LEGACY_MAX_MHZ   85
`define SINGLE_MAX_MHZ   96
`define REPL_MAX_MHZ     85
`define DUAL_MIN_MHZ     96
`define DUAL_MAX_MHZ     170
`define MHZ_TICKS(m)     (((m) * `WIN_US) / `TICK_DIV)

`endif

// ===== hw/i2c_reg_port.v
// i2c style register port: device address, register pointer, data bytes
// assumes scl and sda are already synchronous to clock
`timescale 1ns/1ps
`default_nettype none

module i2c_reg_port #(
    parameter [6:0] DEV_ADDR = 7'h00
) (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_oe,
    // register side
    input  wire [7:0] rd_data,
    output wire [7:0] reg_addr,
    output wire [7:0] wr_data,
    output wire       wr_stb
);

    localparam [8:0] S_IDLE   = 9'h001;
    localparam [8:0] S_ADDR   = 9'h002;
    localparam [8:0] S_ACK_A  = 9'h004;
    localparam [8:0] S_REG    = 9'h008;
    localparam [8:0] S_ACK_R  = 9'h010;
    localparam [8:0] S_WR     = 9'h020;
    localparam [8:0] S_ACK_W  = 9'h040;
    localparam [8:0] S_RD     = 9'h080;
    localparam [8:0] S_ACK_RD = 9'h100;

    reg [8:0] state_ff;
    reg [7:0] shift_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] ptr_ff;
    reg       rw_ff;
    reg       oe_ff;
    reg       wr_stb_ff;
    reg       scl_q;
    reg       sda_q;

    // bus events from previous and current pin levels
    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    wire start    = scl_in & scl_q & sda_q & ~sda_in;
    wire stop     = scl_in & scl_q & ~sda_q & sda_in;
    wire rx_state = (state_ff == S_ADDR) | (state_ff == S_REG) | (state_ff == S_WR);

    assign sda_oe   = oe_ff;
    assign reg_addr = ptr_ff;
    assign wr_data  = shift_ff;
    assign wr_stb   = wr_stb_ff;

    // byte engine: sample on scl rise, drive on scl fall
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff   <= S_IDLE;
            shift_ff   <= 8'h00;
            bit_cnt_ff <= 4'h0;
            ptr_ff     <= 8'h00;
            rw_ff      <= 1'b0;
            oe_ff      <= 1'b0;
            wr_stb_ff  <= 1'b0;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
        end else begin
            scl_q     <= scl_in;
            sda_q     <= sda_in;
            wr_stb_ff <= 1'b0;
            if (start) begin
                state_ff   <= S_ADDR;
                bit_cnt_ff <= 4'h0;
                oe_ff      <= 1'b0;
            end else if (stop) begin
                state_ff <= S_IDLE;
                oe_ff    <= 1'b0;
            end else if (scl_rise) begin
                if (rx_state) begin
                    shift_ff   <= {shift_ff[6:0], sda_in};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
                if (state_ff == S_RD)
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                if (state_ff == S_ACK_RD) begin
                    if (sda_in)
                        state_ff <= S_IDLE; // master nack ends the read
                    else
                        ptr_ff <= ptr_ff + 8'h01;
                end
            end else if (scl_fall) begin
                case (state_ff)
                    S_ADDR: if (bit_cnt_ff == 4'h8) begin
                        bit_cnt_ff <= 4'h0;
                        if (shift_ff[7:1] == DEV_ADDR) begin
                            state_ff <= S_ACK_A;
                            oe_ff    <= 1'b1;
                            rw_ff    <= shift_ff[0];
                        end else
                            state_ff <= S_IDLE;
                    end
                    S_ACK_A: if (rw_ff) begin
                        state_ff <= S_RD;
                        shift_ff <= rd_data;
                        oe_ff    <= ~rd_data[7];
                    end else begin
                        state_ff <= S_REG;
                        oe_ff    <= 1'b0;
                    end
                    S_REG: if (bit_cnt_ff == 4'h8) begin
                        bit_cnt_ff <= 4'h0;
                        ptr_ff     <= shift_ff;
                        state_ff   <= S_ACK_R;
                        oe_ff      <= 1'b1;
                    end
                    S_ACK_R: begin
                        oe_ff    <= 1'b0;
                        state_ff <= S_WR;
                    end
                    S_WR: if (bit_cnt_ff == 4'h8) begin
                        bit_cnt_ff <= 4'h0;
                        wr_stb_ff  <= 1'b1;
                        state_ff   <= S_ACK_W;
                        oe_ff      <= 1'b1;
                    end
                    S_ACK_W: begin
                        oe_ff    <= 1'b0;
                        ptr_ff   <= ptr_ff + 8'h01;
                        state_ff <= S_WR;
                    end
                    S_RD: if (bit_cnt_ff == 4'h8) begin
                        bit_cnt_ff <= 4'h0;
                        oe_ff      <= 1'b0;
                        state_ff   <= S_ACK_RD;
                    end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        oe_ff    <= ~shift_ff[6];
                    end
                    S_ACK_RD: begin
                        state_ff <= S_RD;
                        shift_ff <= rd_data;
                        oe_ff    <= ~rd_data[7];
                    end
                    default: state_ff <= state_ff;
                endcase
            end
        end
    end

endmodule // i2c_reg_port

`default_nettype wire

// ===== hw/serializer_mode_config_link_select.v
// strap capture, configuration registers and link mode selection
// assumes straps arrive as level codes 0..7 and pclk_tick pulses once
// per 64 pixel clocks, all synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "ser_mode_regs.vh"

// Overview of operation
// - sample both straps once after power-up and latch decoded bits
// - software reads and overwrites latched bits; registers govern afterwards
// - first strap levels give dual-pixel and repeater bits
// - second strap level pairs give map-select and cable bits
// - dual-pixel value stored inverted in input format bit 6
// - repeater value stored in repeater config bit 5
// - bit-map value stored in input format bit 7
// - cable value stored in link control bit 7
// - single link sends whole stream on one link up to 96 MHz
// - legacy receiver single link only below 85 MHz
// - forced single disables secondary transmitter and back channel
// - dual link sends alternating pixels on both links
// - dual link accepts up to 170 MHz, ports at half rate
// - dual entered automatically for dual receiver at or above minimum, or forced
// - replicate sends same video up to 85 MHz to two receivers
// - detection tells single, dual-capable and two independent receivers apart
// - measured pixel frequency and receiver kind pick the mode
// - two independent receivers select replicate mode
// - receiver only on secondary link gets video on secondary alone
// - software can turn off auto detection and force a mode
module serializer_mode_config_link_select #(
    parameter [6:0] DEV_ADDR = `I2C_DEV_ADDR
) (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // control bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    // mode straps as level codes
    input  wire [2:0] first_mode_strap,
    input  wire [2:0] second_mode_strap,
    // pixel clock prescaler pulse
    input  wire       pclk_tick,
    // downstream receiver detection
    input  wire       rx0_present,
    input  wire       rx0_dual_cap,
    input  wire       rx0_legacy,
    input  wire       rx1_present,
    input  wire       rx1_legacy,
    // link controls
    output wire       primary_tx_en,
    output wire       secondary_tx_en,
    output wire       secondary_bc_en,
    output wire       alt_pixel_split,
    output wire       half_rate_tx,
    output wire       video_enable,
    output wire [2:0] link_mode_status,
    // configuration bits
    output wire       dual_pixel_input,
    output wire       repeater_enable,
    output wire       alt_map_select,
    output wire       cable_type_strap_cable
);

    // ==============================================================
    // states and constants
    localparam [5:0] ST_RESOLVE = 6'h01;
    localparam [5:0] ST_SINGLE  = 6'h02;
    localparam [5:0] ST_DUAL    = 6'h04;
    localparam [5:0] ST_REPL    = 6'h08;
    localparam [5:0] ST_SECOND  = 6'h10;
    localparam [5:0] ST_IDLE    = 6'h20;

    localparam [11:0] WIN_LAST   = `WIN_CYC - 1;
    localparam [9:0]  T_LEGACY   = `MHZ_TICKS(`LEGACY_MAX_MHZ);
    localparam [9:0]  T_SINGLE   = `MHZ_TICKS(`SINGLE_MAX_MHZ);
    localparam [9:0]  T_REPL     = `MHZ_TICKS(`REPL_MAX_MHZ);
    localparam [9:0]  T_DUAL_MIN = `MHZ_TICKS(`DUAL_MIN_MHZ);
    localparam [9:0]  T_DUAL_MAX = `MHZ_TICKS(`DUAL_MAX_MHZ);

    // ==============================================================
    // decode functions
    function [1:0] dec_first; // {dual_pixel, repeater}
        input [2:0] lvl;
        dec_first = {lvl[2], lvl[0]};
    endfunction

    function [1:0] dec_second; // {map_sel, cable}
        input [2:0] lvl;
        dec_second = {lvl[2], lvl[1]};
    endfunction

    // single link fit: legacy strictly below, otherwise up to the limit
    function fits_single;
        input [9:0] t;
        input       legacy;
        fits_single = legacy ? (t < T_LEGACY) : (t <= T_SINGLE);
    endfunction

    function [2:0] stat_code;
        input [5:0] st;
        case (st)
            ST_SINGLE: stat_code = `STAT_SINGLE;
            ST_DUAL:   stat_code = `STAT_DUAL;
            ST_REPL:   stat_code = `STAT_REPL;
            ST_SECOND: stat_code = `STAT_SECOND;
            ST_IDLE:   stat_code = `STAT_IDLE;
            default:   stat_code = `STAT_RESOLVE;
        endcase
    endfunction

    // ==============================================================
    // registers and state
    reg [7:0]  fmt_ff;
    reg [7:0]  ctl_ff;
    reg [7:0]  rptr_ff;
    reg        strap_done_ff;
    reg [11:0] win_cnt_ff;
    reg [9:0]  tick_cnt_ff;
    reg [9:0]  ticks_ff;
    reg        win_end_ff;
    reg [5:0]  state_ff;
    reg [5:0]  pending_ff;
    reg        tx0_ff;
    reg        tx1_ff;
    reg        bc1_ff;
    reg        split_ff;
    reg        half_ff;
    reg        video_ff;
    reg [2:0]  stat_ff;
    reg [5:0]  nxt_target;
    reg [7:0]  nxt_rd_data;

    wire [7:0] bus_addr;
    wire [7:0] bus_wdata;
    wire       bus_wr;
    wire       auto_off = ctl_ff[`BIT_AUTO_OFF];
    wire [1:0] force_mode = ctl_ff[`FLD_FORCE_HI:`FLD_FORCE_LO];
    wire [1:0] first_dec = dec_first(first_mode_strap);
    wire [1:0] second_dec = dec_second(second_mode_strap);

    // ==============================================================
    // control bus port
    i2c_reg_port #(
        .DEV_ADDR (DEV_ADDR)
    ) i_i2c_reg_port (
        .clock    (clock),
        .rst      (rst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe   (sda_oe),
        .rd_data  (nxt_rd_data),
        .reg_addr (bus_addr),
        .wr_data  (bus_wdata),
        .wr_stb   (bus_wr)
    );

    // open drain: only ever pulls low
    assign sda_out = 1'b0;

    // read mux, status field overlays the link control register
    always @* begin
        case (bus_addr)
            `ADDR_INPUT_FMT: nxt_rd_data = fmt_ff;
            `ADDR_LINK_CTL: begin
                nxt_rd_data = ctl_ff;
                nxt_rd_data[`FLD_STAT_HI:`FLD_STAT_LO] = stat_ff;
            end
            `ADDR_RPTR_CFG:  nxt_rd_data = rptr_ff;
            default:         nxt_rd_data = 8'h00;
        endcase
    end

    // ==============================================================
    // configuration registers with one-time strap capture
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            fmt_ff        <= `RST_INPUT_FMT;
            ctl_ff        <= `RST_LINK_CTL;
            rptr_ff       <= `RST_RPTR_CFG;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_done_ff              <= 1'b1;
            fmt_ff[`BIT_PIX_WIDTH]     <= ~first_dec[1];
            rptr_ff[`BIT_RPTR_EN]      <= first_dec[0];
            fmt_ff[`BIT_MAP_SEL]       <= second_dec[1];
            ctl_ff[`BIT_CABLE]         <= second_dec[0];
        end else if (bus_wr) begin
            // software overwrite of any latched value
            case (bus_addr)
                `ADDR_INPUT_FMT: fmt_ff  <= bus_wdata;
                `ADDR_LINK_CTL:  ctl_ff  <= bus_wdata;
                `ADDR_RPTR_CFG:  rptr_ff <= bus_wdata;
                default:         ctl_ff  <= ctl_ff;
            endcase
        end
    end

    // configuration outputs come from the register bits
    assign dual_pixel_input = ~fmt_ff[`BIT_PIX_WIDTH];
    assign repeater_enable  = rptr_ff[`BIT_RPTR_EN];
    assign alt_map_select   = fmt_ff[`BIT_MAP_SEL];
    assign cable_type_strap_cable       = ctl_ff[`BIT_CABLE];

    // ==============================================================
    // pixel clock frequency measurement over a fixed window
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            win_cnt_ff  <= 12'h000;
            tick_cnt_ff <= 10'h000;
            ticks_ff    <= 10'h000;
            win_end_ff  <= 1'b0;
        end else begin
            win_end_ff <= (win_cnt_ff == WIN_LAST);
            if (win_cnt_ff == WIN_LAST) begin
                win_cnt_ff  <= 12'h000;
                ticks_ff    <= tick_cnt_ff;
                tick_cnt_ff <= {9'h000, pclk_tick};
            end else begin
                win_cnt_ff <= win_cnt_ff + 12'h001;
                if (pclk_tick && tick_cnt_ff != 10'h3FF)
                    tick_cnt_ff <= tick_cnt_ff + 10'h001;
            end
        end
    end

    // ==============================================================
    // target mode from receivers, frequency and forced settings
    always @* begin
        nxt_target = ST_IDLE;
        if (auto_off) begin
            case (force_mode)
                `FORCE_SINGLE: nxt_target = ST_SINGLE;
                `FORCE_DUAL:   nxt_target = ST_DUAL;
                `FORCE_REPL:   nxt_target = ST_REPL;
                default:       nxt_target = ST_SECOND;
            endcase
        end else if (ticks_ff == 10'h000) begin
            nxt_target = ST_IDLE; // no pixel clock, nothing to send
        end else if (rx0_present && rx0_dual_cap && rx1_present) begin
            // one dual-capable receiver on both links
            if (ticks_ff >= T_DUAL_MIN && ticks_ff <= T_DUAL_MAX)
                nxt_target = ST_DUAL;
            else if (fits_single(ticks_ff, 1'b0))
                nxt_target = ST_SINGLE;
        end else if (rx0_present && rx1_present) begin
            // two independent receivers
            if (ticks_ff <= T_REPL && fits_single(ticks_ff, rx0_legacy | rx1_legacy))
                nxt_target = ST_REPL;
        end else if (rx0_present) begin
            if (fits_single(ticks_ff, rx0_legacy))
                nxt_target = ST_SINGLE;
        end else if (rx1_present) begin
            if (fits_single(ticks_ff, rx1_legacy))
                nxt_target = ST_SECOND;
        end
    end

    // ==============================================================
    // mode state: change goes through resolve, committed on a stable window
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff   <= ST_RESOLVE;
            pending_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_RESOLVE: if (win_end_ff) begin
                    if (pending_ff == nxt_target)
                        state_ff <= pending_ff;
                    else
                        pending_ff <= nxt_target;
                end
                ST_SINGLE, ST_DUAL, ST_REPL, ST_SECOND, ST_IDLE:
                    if (nxt_target != state_ff) begin
                        state_ff   <= ST_RESOLVE;
                        pending_ff <= nxt_target;
                    end
                default: state_ff <= ST_RESOLVE;
            endcase
        end
    end

    // ==============================================================
    // registered link controls derived from the mode state
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            tx0_ff   <= 1'b0;
            tx1_ff   <= 1'b0;
            bc1_ff   <= 1'b0;
            split_ff <= 1'b0;
            half_ff  <= 1'b0;
            video_ff <= 1'b0;
            stat_ff  <= `STAT_RESOLVE;
        end else begin
            stat_ff  <= stat_code(state_ff);
            tx0_ff   <= (state_ff == ST_SINGLE) | (state_ff == ST_DUAL)
                      | (state_ff == ST_REPL);
            tx1_ff   <= (state_ff == ST_DUAL) | (state_ff == ST_REPL)
                      | (state_ff == ST_SECOND);
            bc1_ff   <= (state_ff == ST_DUAL) | (state_ff == ST_REPL)
                      | (state_ff == ST_SECOND);
            split_ff <= (state_ff == ST_DUAL);
            half_ff  <= (state_ff == ST_DUAL);
            video_ff <= (state_ff != ST_RESOLVE) & (state_ff != ST_IDLE);
        end
    end

    assign primary_tx_en    = tx0_ff;
    assign secondary_tx_en  = tx1_ff;
    assign secondary_bc_en  = bc1_ff;
    assign alt_pixel_split  = split_ff;
    assign half_rate_tx     = half_ff;
    assign video_enable     = video_ff;
    assign link_mode_status = stat_ff;

endmodule // serializer_mode_config_link_select

`default_nettype wire

// ===== test/mode_link_properties.sv
// checker on the link mode outputs and the configuration bits
// assumes it is bound to the top module and sees one clock domain
`timescale 1ns/1ps
`default_nettype none
// ==========
// link mode checker
module mode_link_properties (
    // clock, reset and bus
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_oe,
    // link outputs
    input wire logic       primary_tx_en,
    input wire logic       secondary_tx_en,
    input wire logic       alt_pixel_split,
    input wire logic       half_rate_tx,
    input wire logic       video_enable,
    input wire logic [2:0] link_mode_status,
    // configuration bits
    input wire logic       dual_pixel_input,
    input wire logic       repeater_enable,
    input wire logic       alt_map_select,
    input wire logic       cable_type_strap_cable
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // status held in one mode for two cycles
    sequence held(logic [2:0] s);
        (link_mode_status == s) [*2];
    endsequence
    chk_video_has_link: assert property (
        video_enable |-> primary_tx_en || secondary_tx_en) else $error("video with no link");
    chk_split_dual: assert property (
        alt_pixel_split |-> half_rate_tx && primary_tx_en && secondary_tx_en)
        else $error("split without dual links");
    chk_split_mode: assert property (
        alt_pixel_split |-> link_mode_status == 3'h2 || $past(link_mode_status) == 3'h2)
        else $error("split outside dual mode");
    chk_repl_both: assert property (
        held(3'h3) |-> primary_tx_en && secondary_tx_en && !alt_pixel_split)
        else $error("replicate links wrong");
    chk_second_only: assert property (
        held(3'h4) |-> secondary_tx_en && !primary_tx_en) else $error("secondary only wrong");
    chk_single_one: assert property (
        held(3'h1) |-> primary_tx_en && !alt_pixel_split && !half_rate_tx)
        else $error("single link wrong");
    chk_resolve_idle: assert property (
        held(3'h0) |-> !video_enable && !primary_tx_en && !secondary_tx_en)
        else $error("outputs active while resolving");
    chk_cfg_on_write: assert property (
        $changed({dual_pixel_input, repeater_enable, alt_map_select, cable_type_strap_cable})
        && !$past(rst, 2) |-> !scl_in) else $error("config moved outside a write");
    chk_sda_scl_low: assert property (
        $changed(sda_oe) |-> !scl_in) else $error("sda drive changed while scl high");
endmodule // mode_link_properties
bind serializer_mode_config_link_select mode_link_properties i_mode_link_properties (.*);
`default_nettype wire

// ===== test/rx_link_model.sv
// downstream receivers and pixel clock prescaler seen by the serializer
// assumes the bench picks which receivers are attached and the tick period
`timescale 1ns/1ps
`default_nettype none
// ==========
// receiver model
module rx_link_model (
    // clock
    input  wire logic       clock,
    // scenario controls
    input  wire logic [1:0] attach,
    input  wire logic       dual_cap,
    input  wire logic       legacy,
    input  wire logic [7:0] tick_period,
    // detection levels and tick
    output var  logic       rx0_present,
    output var  logic       rx0_dual_cap,
    output var  logic       rx0_legacy,
    output var  logic       rx1_present,
    output var  logic       rx1_legacy,
    output var  logic       pclk_tick
);
    logic [7:0] tick_cnt_ff = 8'h00;
    // one tick per period; attach bit 0 is primary, bit 1 secondary
    always @(posedge clock) begin
        tick_cnt_ff  <= #2 (tick_cnt_ff >= tick_period - 8'h01) ? 8'h00 : tick_cnt_ff + 8'h01;
        pclk_tick    <= #2 (tick_cnt_ff == 8'h00);
        rx0_present  <= #2 attach[0];
        rx0_dual_cap <= #2 attach[0] & dual_cap;
        rx0_legacy   <= #2 attach[0] & legacy;
        rx1_present  <= #2 attach[1];
        rx1_legacy   <= #2 attach[1] & legacy;
    end
endmodule // rx_link_model
`default_nettype wire

// ===== test/serializer_mode_config_link_select_bench.sv
// bench for strap capture, registers and link mode selection
// assumes a 40 MHz clock and the bus pins already synchronous
`timescale 1ns/1ps
`default_nettype none
`include "ser_mode_regs.vh"
// ==========
// bench top
module serializer_mode_config_link_select_bench;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       scl_in = 1'b1;
    logic       m_sda = 1'b1;
    logic [2:0] first_mode_strap = 3'h0;
    logic [2:0] second_mode_strap = 3'h0;
    logic [1:0] attach = 2'h0;
    logic       dual_cap = 1'b0;
    logic       legacy = 1'b0;
    logic [7:0] tick_period = 8'h28;
    logic [7:0] rd;
    int         num_errors = 0;
    int         n_tests = 0;
    int         i;
    wire        sda_oe, primary_tx_en, secondary_tx_en, secondary_bc_en, alt_pixel_split;
    wire        half_rate_tx, video_enable, dual_pixel_input, repeater_enable;
    wire        alt_map_select, cable_type_strap_cable, pclk_tick;
    wire        rx0_present, rx0_dual_cap, rx0_legacy, rx1_present, rx1_legacy;
    wire [2:0]  link_mode_status;
    // open drain line: high unless someone pulls it low
    wire        sda_in = m_sda & ~sda_oe;
    serializer_mode_config_link_select i_serializer_mode_config_link_select (.*, .sda_out());
    rx_link_model i_rx_link_model (.*);
    always #12.5 clock = ~clock;
    // ==========
    // tasks
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task hp;
        repeat (4) @(posedge clock);
        #2;
    endtask
    task bit_io(input logic b, output logic r);
        m_sda = b;
        hp;
        scl_in = 1'b1;
        hp;
        r = sda_in;
        hp;
        scl_in = 1'b0;
        hp;
    endtask
    task start;
        m_sda = 1'b1;
        hp;
        scl_in = 1'b1;
        hp;
        m_sda = 1'b0;
        hp;
        scl_in = 1'b0;
        hp;
    endtask
    task put_byte(input logic [7:0] b);
        logic r;
        for (int k = 7; k >= 0; k--) bit_io(b[k], r);
        bit_io(1'b1, r);
    endtask
    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        start;
        put_byte({`I2C_DEV_ADDR, 1'b0});
        put_byte(a);
        put_byte(d);
        m_sda = 1'b0;
        hp;
        scl_in = 1'b1;
        hp;
        m_sda = 1'b1;
        hp;
    endtask
    // pointer set by a write, then repeated start and a one byte read
    task reg_rd(input logic [7:0] a, output logic [7:0] v);
        logic r;
        start;
        put_byte({`I2C_DEV_ADDR, 1'b0});
        put_byte(a);
        start;
        put_byte({`I2C_DEV_ADDR, 1'b1});
        for (int k = 7; k >= 0; k--) bit_io(1'b1, v[k]);
        bit_io(1'b1, r);
        m_sda = 1'b0;
        hp;
        scl_in = 1'b1;
        hp;
        m_sda = 1'b1;
        hp;
    endtask
    task wait_mode(input logic [2:0] s);
        int k;
        k = 0;
        while (link_mode_status !== s && k < 12000) begin
            @(posedge clock);
            k++;
        end
        hp;
        check({5'h00, link_mode_status}, {5'h00, s});
    endtask
    // outputs order: primary, secondary, back channel, split, half rate, video
    task run_mode(input logic [1:0] a, input logic d, input logic [7:0] p,
                  input logic [2:0] s, input logic [5:0] e);
        attach = a;
        dual_cap = d;
        tick_period = p;
        wait_mode(s);
        check({2'h0, primary_tx_en, secondary_tx_en, secondary_bc_en, alt_pixel_split,
               half_rate_tx, video_enable}, {2'h0, e});
    endtask
    // ==========
    // main sequence
    initial begin
        for (i = 0; i < 8; i++) begin
            first_mode_strap = {i[1], 1'b0, i[0]};
            second_mode_strap = i[2:0];
            rst = 1'b1;
            repeat (16) @(posedge clock);
            #2;
            rst = 1'b0;
            hp;
            check({4'h0, dual_pixel_input, repeater_enable, alt_map_select, cable_type_strap_cable},
                  {4'h0, i[1], i[0], i[2], i[1]});
        end
        reg_rd(`ADDR_INPUT_FMT, rd);
        check(rd, 8'h80);
        reg_rd(`ADDR_RPTR_CFG, rd);
        check(rd, 8'h20);
        reg_rd(`ADDR_LINK_CTL, rd);
        check(rd & 8'hC7, 8'h80);
        reg_rd(8'h10, rd);
        check(rd, 8'h00);
        reg_wr(`ADDR_INPUT_FMT, 8'h40);
        reg_wr(`ADDR_RPTR_CFG, 8'h00);
        check({5'h00, dual_pixel_input, repeater_enable, alt_map_select}, 8'h00);
        reg_rd(`ADDR_INPUT_FMT, rd);
        check(rd, 8'h40);
        run_mode(2'h1, 1'b0, 8'h28, 3'h1, 6'h21);
        legacy = 1'b1;
        run_mode(2'h3, 1'b0, 8'h28, 3'h3, 6'h39);
        legacy = 1'b0;
        run_mode(2'h2, 1'b0, 8'h28, 3'h4, 6'h19);
        run_mode(2'h3, 1'b1, 8'h14, 3'h2, 6'h3F);
        for (i = 3; i >= 0; i--) begin
            reg_wr(`ADDR_LINK_CTL, {5'h00, i[1:0], 1'b1});
            wait_mode(i[2:0] + 3'h1);
        end
        check({6'h00, secondary_tx_en, secondary_bc_en}, 8'h00);
        conclude;
    end
    // watchdog: a few windows per mode
    initial begin
        #(25 * 90000);
        num_errors++;
        conclude;
    end
endmodule // serializer_mode_config_link_select_bench
`default_nettype wire
